// File: src/csfpm_pkg.sv
// package for the clock switch, fail-safe monitor and power-mode controller
// assumes a single ref_clk domain and an AHB-Lite register bus
package csfpm_pkg;
    // source codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC_SOURCE = 3'h5;
    localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FRC_DIVN = 3'h7;
    // register byte addresses
    localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK = 8'h04;
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_PWR_STAT = 8'h0C;
    // control register fields
    localparam int CUR_LSB = 12;
    localparam int NEW_LSB = 8;
    localparam int LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int KEEP_BIT = 1;
    localparam int REQ_BIT = 0;
    // unlock keys, written in order to the unlock register
    localparam logic [15:0] UNLOCK_KEY1 = 16'h0055;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h00AA;
    // power command codes in the power control register
    localparam logic [1:0] PCMD_SLEEP = 2'h1;
    localparam logic [1:0] PCMD_IDLE = 2'h2;
    // changeover delay in new-source cycles
    localparam int SETTLE_CYCLES = 10;
    localparam int CNT_W = 16;
    typedef enum logic [5:0] {
        CSF_IDLE = 6'h01,
        CSF_START = 6'h02,
        CSF_XTAL = 6'h04,
        CSF_PLL = 6'h08,
        CSF_SETTLE = 6'h10,
        CSF_DONE = 6'h20
    } csfpm_sw_e;
endpackage

// File: src/csfpm_ctrl.sv
// clock switch sequencer, fail-safe monitor and sleep/idle control
// assumes new-source tick, lock and fail indications come from other
// clock domains and are synchronised here; all logic runs on ref_clk
//
// Functional notes
// - switching and fail-safe work only when switch fuse reads zero
// - switching disabled: new select ignored, current shows reset fuse source
// - switching disabled: switch request has no effect, reads zero
// - request with current equal new clears request and aborts
// - valid switch start clears lock and clock-fail status
// - start new oscillator if off; crystal waits for start-up timer
// - PLL source waits for PLL lock before continuing
// - count ten new-source cycles, then change system clock over
// - at changeover clear request, copy new select to current
// - stop old source except kept low-power RC or secondary
// - fail-safe enabled keeps low-power RC running except in sleep
// - oscillator failure raises trap and falls back to fast RC
// - failure while PLL in use falls back to fast RC with PLL
// - sleep stops system clock, oscillators, monitor and clocked peripherals
// - watchdog enabled: clear before sleep, low-power RC stays on
// - wake on enabled interrupt, any reset or watchdog time-out
// - sleep wake resumes on the source active at entry; code uses cur_ff, which a switch finishing in sleep changes
// - idle stops CPU, clock and peripherals run, watchdog cleared
// - idle wake reapplies CPU clock and resumes immediately
// - clock-fail flag reads one after failure until software clears
// - control register writes take effect only after unlock sequence
// - source codes zero to seven in the documented order
// - interrupt during power-save entry is held, then wakes the device
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module csfpm_ctrl
    import csfpm_pkg::*;
#(
    parameter int XTAL_WAIT = 1024
) (
    input wire logic ref_clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // configuration fuses
    input wire logic switch_enable_fuse,
    input wire logic [2:0] reset_source_fuse,
    input wire logic [1:0] primary_submode_fuse,
    input wire logic watchdog_enable,
    // oscillator status from analog side (asynchronous)
    input wire logic new_clk_tick,
    input wire logic pll_lock_in,
    input wire logic osc_fail_in,
    // wake sources
    input wire logic irq_pending,
    input wire logic watchdog_timeout,
    // outputs
    output logic [2:0] sysclk_select,
    output logic [7:0] osc_enable,
    output logic low_power_rc_on,
    output logic primary_xtal_mode,
    output logic clock_fail_trap,
    output logic watchdog_clear,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic sleep_active,
    output logic idle_active,
    output logic wake_pulse
);
    ////////////////////////////////////////////////////////////////////
    // input synchronisers: first stage read only by second stage
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic tick_last_ff;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            tick_last_ff <= 1'b0;
        end else begin
            sync1_ff <= {osc_fail_in, pll_lock_in, new_clk_tick};
            sync2_ff <= sync1_ff;
            tick_last_ff <= sync2_ff[0];
        end
    end
    wire tick_rise = sync2_ff[0] & ~tick_last_ff;
    wire pll_locked = sync2_ff[1];
    wire osc_failed = sync2_ff[2];

    // source code decode
    // source decode helpers
    function automatic logic uses_pll(input logic [2:0] src);
        uses_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
    endfunction
    function automatic logic is_xtal(input logic [2:0] src);
        is_xtal = (src == SRC_PRI) || (src == SRC_PRI_PLL) || (src == SRC_SEC);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic wr_ph_ff;
    logic rd_ph_ff;
    logic [7:0] addr_ff;
    wire take = hsel & hready & htrans[1];
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ph_ff <= 1'b0;
            rd_ph_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else begin
            wr_ph_ff <= take & hwrite;
            rd_ph_ff <= take & ~hwrite;
            if (take) begin
                addr_ff <= haddr;
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire wr_ctrl = wr_ph_ff && (addr_ff == ADDR_OSC_CTRL);
    wire wr_unlock = wr_ph_ff && (addr_ff == ADDR_UNLOCK);
    wire wr_pwr = wr_ph_ff && (addr_ff == ADDR_PWR_CTRL);

    ////////////////////////////////////////////////////////////////////
    // unlock sequence: two keys arm a single control write
    logic [1:0] unlock_ff;
    logic [1:0] nxt_unlock;
    assign nxt_unlock = wr_ctrl ? 2'h0 :
        !wr_unlock ? unlock_ff :
        (hwdata[15:0] == UNLOCK_KEY1) ? 2'h1 :
        (hwdata[15:0] == UNLOCK_KEY2 && unlock_ff == 2'h1) ? 2'h2 : 2'h0;
    wire ctrl_ok = wr_ctrl && (unlock_ff == 2'h2);

    ////////////////////////////////////////////////////////////////////
    // switch sequencer state
    csfpm_sw_e state_ff;
    csfpm_sw_e nxt_state;
    logic [2:0] cur_ff;
    logic [2:0] new_ff;
    logic [2:0] old_ff;
    logic req_ff;
    logic keep_ff;
    logic lock_ff;
    logic fail_ff;
    logic trap_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic init_ff;
    wire sw_en = ~switch_enable_fuse;
    wire fs_en = ~switch_enable_fuse;
    wire fail_evt = fs_en & osc_failed & ~fail_ff & ~sleep_active;
    wire [2:0] fallback = uses_pll(cur_ff) ? SRC_FRC_PLL : SRC_FRC;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CSF_IDLE: begin
                if (req_ff && sw_en) begin
                    nxt_state = CSF_START;
                end
            end
            CSF_START: begin
                if (new_ff == cur_ff) begin
                    nxt_state = CSF_IDLE;
                end else if (is_xtal(new_ff)) begin
                    nxt_state = CSF_XTAL;
                end else if (uses_pll(new_ff)) begin
                    nxt_state = CSF_PLL;
                end else begin
                    nxt_state = CSF_SETTLE;
                end
            end
            CSF_XTAL: begin
                if (cnt_ff == CNT_W'(XTAL_WAIT - 1)) begin
                    nxt_state = uses_pll(new_ff) ? CSF_PLL : CSF_SETTLE;
                end
            end
            CSF_PLL: begin
                if (lock_ff) begin
                    nxt_state = CSF_SETTLE;
                end
            end
            CSF_SETTLE: begin
                if (tick_rise && cnt_ff == CNT_W'(SETTLE_CYCLES - 1)) begin
                    nxt_state = CSF_DONE;
                end
            end
            CSF_DONE: nxt_state = CSF_IDLE;
            default: nxt_state = CSF_IDLE;
        endcase
        if (fail_evt) begin
            nxt_state = CSF_IDLE;
        end
    end

    wire cnt_clr = (state_ff != nxt_state);
    wire cnt_inc = (state_ff == CSF_XTAL) || ((state_ff == CSF_SETTLE) && tick_rise);
    wire sw_start = (state_ff == CSF_START) && (new_ff != cur_ff) && !fail_evt;

    // sequencer and status registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_ff <= CSF_IDLE;
            cnt_ff <= '0;
            unlock_ff <= 2'h0;
            init_ff <= 1'b1;
            cur_ff <= SRC_FRC;
            new_ff <= SRC_FRC;
            old_ff <= SRC_FRC;
            req_ff <= 1'b0;
            keep_ff <= 1'b0;
            lock_ff <= 1'b0;
            fail_ff <= 1'b0;
            trap_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            unlock_ff <= nxt_unlock;
            init_ff <= 1'b0;
            trap_ff <= fail_evt;
            cnt_ff <= cnt_clr ? '0 : (cnt_inc ? cnt_ff + 1'b1 : cnt_ff);
            lock_ff <= pll_locked;
            if (init_ff || !sw_en) begin
                cur_ff <= reset_source_fuse;
                new_ff <= reset_source_fuse;
            end
            if (ctrl_ok) begin
                keep_ff <= hwdata[KEEP_BIT];
                if (sw_en && state_ff == CSF_IDLE) begin
                    new_ff <= hwdata[NEW_LSB +: 3];
                    req_ff <= hwdata[REQ_BIT];
                end
                if (!hwdata[FAIL_BIT]) begin
                    fail_ff <= 1'b0;
                end
            end
            if (!sw_en) begin
                req_ff <= 1'b0;
            end
            if (state_ff == CSF_START && new_ff == cur_ff) begin
                req_ff <= 1'b0;
            end
            if (sw_start) begin
                lock_ff <= 1'b0;
                fail_ff <= 1'b0;
            end
            if (state_ff == CSF_DONE) begin
                req_ff <= 1'b0;
                old_ff <= cur_ff;
                cur_ff <= new_ff;
            end
            if (fail_evt) begin
                fail_ff <= 1'b1;
                req_ff <= 1'b0;
                old_ff <= cur_ff;
                cur_ff <= fallback;
                new_ff <= fallback;
            end
        end
    end
    assign clock_fail_trap = trap_ff;

    ////////////////////////////////////////////////////////////////////
    // power-save modes
    logic sleep_ff;
    logic idle_ff;
    logic wake_ff;
    logic wdclr_ff;
    logic [2:0] sleep_src_ff;
    wire wake_src = irq_pending | watchdog_timeout;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sleep_ff <= 1'b0;
            idle_ff <= 1'b0;
            wake_ff <= 1'b0;
            wdclr_ff <= 1'b0;
            sleep_src_ff <= SRC_FRC;
        end else begin
            wake_ff <= 1'b0;
            wdclr_ff <= 1'b0;
            if (wr_pwr && !sleep_ff && !idle_ff) begin
                wdclr_ff <= 1'b1;
                sleep_ff <= (hwdata[1:0] == PCMD_SLEEP);
                idle_ff <= (hwdata[1:0] == PCMD_IDLE);
                sleep_src_ff <= cur_ff;
            end else if ((sleep_ff || idle_ff) && wake_src) begin
                sleep_ff <= 1'b0;
                idle_ff <= 1'b0;
                wake_ff <= 1'b1;
            end
        end
    end
    assign sleep_active = sleep_ff;
    assign idle_active = idle_ff;
    assign wake_pulse = wake_ff;
    assign watchdog_clear = wdclr_ff;
    assign cpu_clk_en = ~sleep_ff & ~idle_ff;
    assign periph_clk_en = ~sleep_ff;

    ////////////////////////////////////////////////////////////////////
    // oscillator enables and clock select
    // resume source is cur_ff, which a switch finishing while asleep can change
    assign sysclk_select = cur_ff;
    // submode comes straight from the fuse
    assign primary_xtal_mode = (primary_submode_fuse != 2'h3);
    assign low_power_rc_on = (fs_en & ~sleep_ff) | watchdog_enable;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_osc
            localparam logic [2:0] CODE = 3'(gi);
            wire busy = (state_ff != CSF_IDLE) && (new_ff == CODE);
            wire kept = (CODE == SRC_SEC && keep_ff) ||
                (CODE == SRC_LOW_POWER_RC_SOURCE && low_power_rc_on);
            assign osc_enable[gi] = kept || (!sleep_ff && ((cur_ff == CODE) || busy));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // read mux
    wire [15:0] ctrl_rd = {1'b0, cur_ff, 1'b0, new_ff, 2'h0, lock_ff, 1'b0,
        fail_ff, 1'b0, keep_ff, req_ff};
    wire [31:0] rd_mux = (addr_ff == ADDR_OSC_CTRL) ? {16'h0000, ctrl_rd} :
        (addr_ff == ADDR_PWR_STAT) ? {30'h0, idle_ff, sleep_ff} : 32'h0000_0000;
    assign hrdata = rd_ph_ff ? rd_mux : 32'h0000_0000;
endmodule

// File: testbench/csfpm_checker.sv
// checker for the clock switch, fail-safe and power-mode controller
// sees only the controller ports; one ref_clk domain, nrst sync low
`timescale 1ns/10ps
module csfpm_checker
    import csfpm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic switch_enable_fuse,
    input wire logic [2:0] reset_source_fuse,
    input wire logic watchdog_enable,
    input wire logic irq_pending,
    input wire logic watchdog_timeout,
    input wire logic [2:0] sysclk_select,
    input wire logic low_power_rc_on,
    input wire logic clock_fail_trap,
    input wire logic watchdog_clear,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic sleep_active,
    input wire logic idle_active,
    input wire logic wake_pulse
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    AST_BUS_OKAY:
    assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_FUSE_SRC:
    assert property (switch_enable_fuse && $past(switch_enable_fuse) && $past(nrst)
        && $stable(reset_source_fuse) |-> sysclk_select == reset_source_fuse)
        else $error("disabled switching left source off the fuse value");
    AST_NO_TRAP_OFF:
    assert property (switch_enable_fuse && $past(switch_enable_fuse) |-> !clock_fail_trap)
        else $error("trap raised with monitor disabled");
    AST_TRAP_FRC:
    assert property ($rose(clock_fail_trap) |-> ##[0:1]
        (sysclk_select == SRC_FRC || sysclk_select == SRC_FRC_PLL))
        else $error("trap without fallback to fast rc");
    AST_SLEEP_GATE:
    assert property (sleep_active |-> !cpu_clk_en && !periph_clk_en)
        else $error("clocks running in sleep");
    AST_IDLE_GATE:
    assert property (idle_active |-> !cpu_clk_en && periph_clk_en)
        else $error("idle clock gating wrong");
    AST_LOW_POWER_RC_SOURCE_FAIL_SAFE_MONITOR:
    assert property (!switch_enable_fuse && !sleep_active |-> low_power_rc_on)
        else $error("low-power rc off with monitor enabled");
    AST_LOW_POWER_RC_SOURCE_SLEEP:
    assert property (watchdog_enable && sleep_active |-> low_power_rc_on)
        else $error("low-power rc off in sleep with watchdog");
    AST_WDT_CLR:
    assert property ($rose(sleep_active || idle_active) |-> watchdog_clear || $past(watchdog_clear))
        else $error("watchdog not cleared on power-save entry");
    AST_WAKE:
    assert property ((sleep_active || idle_active) && (irq_pending || watchdog_timeout)
        |-> ##[1:2] !(sleep_active || idle_active))
        else $error("no wake on wake source");
    AST_SLEEP_SRC:
    assert property (sleep_active |=> sysclk_select == $past(sysclk_select))
        else $error("source changed while asleep");
    // main scenarios reached
    cover property ($rose(sleep_active));
    cover property ($rose(idle_active));
    cover property (clock_fail_trap);
    cover property (wake_pulse);
endmodule

// File: testbench/clock_switch_failsafe_power_modes_bench.sv
// self-checking bench for the clock switch controller
// assumes the controller answers AHB-Lite with zero wait and okay
`timescale 1ns/10ps
module clock_switch_failsafe_power_modes_bench;
    import csfpm_pkg::*;
    localparam int XW = 8;
    logic ref_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [7:0] haddr = 8'h00, lf = 8'h2D, osc_enable;
    logic [1:0] htrans = 2'h0, primary_submode_fuse = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rq;
    logic [2:0] reset_source_fuse = 3'h0, sysclk_select, cur;
    logic switch_enable_fuse = 1'b1, new_clk_tick = 1'b0, pll_lock_in = 1'b0;
    logic osc_fail_in = 1'b0, irq_pending = 1'b0, watchdog_timeout = 1'b0;
    logic low_power_rc_on, primary_xtal_mode, clock_fail_trap, watchdog_clear;
    logic cpu_clk_en, periph_clk_en, sleep_active, idle_active, wake_pulse;
    logic seen = 1'b0, wcs = 1'b0, wks = 1'b0, wde = 1'b0;
    int err_total = 0, n_tests = 0, cyc = 0, tcnt = 0, lock_t = 0;
    ////////////////////////////////////////////////////////////////////////////
    csfpm_ctrl #(.XTAL_WAIT(XW)) dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .switch_enable_fuse(switch_enable_fuse), .reset_source_fuse(reset_source_fuse),
        .primary_submode_fuse(primary_submode_fuse), .watchdog_enable(wde),
        .new_clk_tick(new_clk_tick), .pll_lock_in(pll_lock_in), .osc_fail_in(osc_fail_in),
        .irq_pending(irq_pending), .watchdog_timeout(watchdog_timeout),
        .sysclk_select(sysclk_select), .osc_enable(osc_enable),
        .low_power_rc_on(low_power_rc_on), .primary_xtal_mode(primary_xtal_mode),
        .clock_fail_trap(clock_fail_trap), .watchdog_clear(watchdog_clear),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .sleep_active(sleep_active), .idle_active(idle_active), .wake_pulse(wake_pulse));
    // clocks; new source free-running, unrelated in phase
    always #12.5 ref_clk = ~ref_clk;
    always #37 new_clk_tick = ~new_clk_tick;
    always @(posedge new_clk_tick) tcnt <= tcnt + 1;
    // pll locks more than 40 cycles after each request; power-mode event capture
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        pll_lock_in <= (cyc - lock_t) > 40;
        if (sleep_active || idle_active) seen <= 1'b1;
        if (watchdog_clear) wcs <= 1'b1;
        if (wake_pulse) wks <= 1'b1;
    end
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one single transfer; held until hready sampled high
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic osc_wr(input logic [31:0] d);
        logic [31:0] q;
        bus(ADDR_UNLOCK, 1'b1, {16'h0, UNLOCK_KEY1}, q);
        bus(ADDR_UNLOCK, 1'b1, {16'h0, UNLOCK_KEY2}, q);
        bus(ADDR_OSC_CTRL, 1'b1, d, q);
    endtask
    task automatic do_rst(input logic f);
        nrst <= 1'b0;
        switch_enable_fuse <= f;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic sw(input logic [2:0] t);
        int c0, k0, n;
        logic [2:0] old;
        old = cur;
        lock_t = cyc;
        c0 = cyc;
        k0 = tcnt;
        osc_wr({21'h0, t, 8'h01});
        bus(ADDR_OSC_CTRL, 1'b0, 32'h0, rq);
        chk(rq[0], 1'b1);
        chk(low_power_rc_on, 1'b1);
        n = 0;
        while (rq[0] !== 1'b0 && n < 400) begin
            bus(ADDR_OSC_CTRL, 1'b0, 32'h0, rq);
            n++;
        end
        chk({rq[14:12], rq[3], sysclk_select}, {t, 1'b0, t});
        chk(tcnt - k0 >= 10, 1'b1);
        chk(osc_enable[t], 1'b1);
        if (t == SRC_PRI || t == SRC_PRI_PLL || t == SRC_SEC) chk(cyc - c0 >= XW, 1'b1);
        if (t == SRC_FRC_PLL || t == SRC_PRI_PLL) chk(cyc - c0 > 40, 1'b1);
        if (old == SRC_SEC) chk(osc_enable[SRC_SEC], 1'b0);
        cur = t;
    endtask
    task automatic fail_chk(input logic [2:0] e);
        int n;
        n = 0;
        osc_fail_in <= 1'b1;
        while (clock_fail_trap !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        osc_fail_in <= 1'b0;
        bus(ADDR_OSC_CTRL, 1'b0, 32'h0, rq);
        chk({n < 20, rq[3], rq[14:12], sysclk_select}, {2'h3, e, e});
        cur = e;
    endtask
    task automatic pwr(input logic [1:0] m, input logic co);
        int n;
        logic [31:0] q;
        seen = 1'b0;
        wcs = 1'b0;
        wks = 1'b0;
        irq_pending <= co;
        bus(ADDR_PWR_CTRL, 1'b1, {30'h0, m}, q);
        if (!co) begin
            repeat (3) @(posedge ref_clk);
            chk({sleep_active, idle_active, cpu_clk_en, periph_clk_en},
                {m == PCMD_SLEEP, m == PCMD_IDLE, 1'b0, m == PCMD_IDLE});
            bus(ADDR_PWR_STAT, 1'b0, 32'h0, q);
            chk(q[1:0], {m == PCMD_IDLE, m == PCMD_SLEEP});
            if (m == PCMD_SLEEP) irq_pending <= 1'b1;
            else watchdog_timeout <= 1'b1;
        end
        n = 0;
        while (wks !== 1'b1 && n < 30) begin
            @(posedge ref_clk);
            n++;
        end
        irq_pending <= 1'b0;
        watchdog_timeout <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({seen, wcs, wks, cpu_clk_en, sysclk_select}, {4'hF, cur});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence: disabled fuse, then switches, failures, power modes
    initial begin
        reset_source_fuse <= lf[2:0];
        primary_submode_fuse <= lf[4:3];
        do_rst(1'b1);
        osc_wr({21'h0, ~reset_source_fuse, 8'h01});
        bus(ADDR_OSC_CTRL, 1'b0, 32'h0, rq);
        chk({rq[14:12], rq[0]}, {reset_source_fuse, 1'b0});
        chk(low_power_rc_on, 1'b0);
        chk(primary_xtal_mode, primary_submode_fuse != 2'h3);
        do_rst(1'b0);
        cur = reset_source_fuse;
        bus(ADDR_OSC_CTRL, 1'b1, {21'h0, ~cur, 8'h01}, rq);
        bus(ADDR_OSC_CTRL, 1'b0, 32'h0, rq);
        chk({rq[14:12], rq[0]}, {cur, 1'b0});
        osc_wr({21'h0, cur, 8'h01});
        repeat (4) bus(ADDR_OSC_CTRL, 1'b0, 32'h0, rq);
        chk({rq[14:12], rq[0], sysclk_select}, {cur, 1'b0, cur});
        for (int i = 0; i < 12; i++) begin
            lf = nxt(lf);
            if (lf[2:0] != cur) begin
                if (lf[2:0] + cur == 3'h4 && lf[0]) sw(SRC_FRC);
                sw(lf[2:0]);
            end
        end
        if (cur != SRC_PRI_PLL) sw(SRC_FRC);
        if (cur != SRC_PRI_PLL) sw(SRC_PRI_PLL);
        fail_chk(SRC_FRC_PLL);
        sw(SRC_FRC);
        sw(SRC_PRI);
        fail_chk(SRC_FRC);
        sw(SRC_SEC);
        // watchdog on only for the power-save part, so the monitor alone keeps rc on above
        wde <= 1'b1;
        pwr(PCMD_SLEEP, 1'b0);
        pwr(PCMD_IDLE, 1'b0);
        pwr(PCMD_IDLE, 1'b1);
        print_verdict();
    end
    // watchdog against a hang
    initial begin
        #(25 * 60000);
        err_total++;
        print_verdict();
    end
endmodule
bind csfpm_ctrl csfpm_checker chk_u (
    .ref_clk(ref_clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
    .switch_enable_fuse(switch_enable_fuse), .reset_source_fuse(reset_source_fuse),
    .watchdog_enable(watchdog_enable), .irq_pending(irq_pending),
    .watchdog_timeout(watchdog_timeout), .sysclk_select(sysclk_select),
    .low_power_rc_on(low_power_rc_on), .clock_fail_trap(clock_fail_trap),
    .watchdog_clear(watchdog_clear), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .sleep_active(sleep_active), .idle_active(idle_active), .wake_pulse(wake_pulse));
